// ===== common/phy_port_map.svh
`ifndef PHY_PORT_MAP_SVH
`define PHY_PORT_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define REG_EVENT_IDX 4'h5
`define REG_SELECT_IDX 4'h7
`define REG_LINE_LINK_IDX 4'h8
`define REG_SPEED_FAULT_IDX 4'h9
`define REG_SPEED_CAP_IDX 4'ha
`define REG_LINK_QUAL_IDX 4'hb
`define REG_CW_ERR_IDX 4'hc
`define REG_LOOP_STBY_IDX 4'hd
`define REG_RSVD_E_IDX 4'he
`define REG_RSVD_F_IDX 4'hf

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SEL_PAGE_MSB 7
`define SEL_PAGE_LSB 5
`define SEL_PORT_MSB 3
`define SEL_PORT_LSB 0
`define LL_DIS_BIT 0
`define SF_SCR_BIT 1
`define SF_SFAULT_BIT 2
`define SF_FAULT_BIT 3
`define SF_PIE_BIT 4
`define SC_MAXSPD_MSB 6
`define SC_MAXSPD_LSB 4
`define LQ_UNREL_BIT 7
`define LS_HARD_BIT 0
`define EV_FLAG_BIT 0

// ----------------------------------------
// Values and timing
// ----------------------------------------
`define PORT_COUNT 3
`define STATUS_PAGE 3'h0
`define PORT_SPEED_CAP 3'h3
`define LOCAL_PLUG 1'h1
`define BETA_ONLY 1'h0
`define ERR_CNT_MAX 8'hff
`define CLK_FREQ_KHZ 200000
`define CON_DEBOUNCE_MS 341
`define DEBOUNCE_W 27

`endif

// ===== common/phy_port_pkg.sv
package phy_port_pkg;

   typedef logic [2:0] speed_t;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ_WAIT,
      BUS_READ_DONE
   } bus_state_e;

   // Per-port status from transceiver, arbitration and negotiation logic
   typedef struct packed {
      logic [1:0] line_a;
      logic [1:0] line_b;
      logic child;
      logic suspended;
      logic raw_connect;
      logic tones_seen;
      logic neg_done;
      speed_t neg_speed;
      logic beta_mode;
      logic bias_ok;
      logic signal_valid;
      logic resume_evt;
      logic suspend_evt;
      logic standby_err;
      logic standby_exit;
      logic standby_remote_clr;
      logic cw_error;
      logic sid_load;
      speed_t sid_speed;
      logic dc_attach;
      logic unreliable_evt;
      logic loop_disable;
      logic in_standby;
      logic port_event;
      logic remote_err_read;
   } port_in_s;

endpackage

// ===== src/phy_port_status_page.sv
`timescale 1ns/1ps
`include "phy_port_map.svh"
module phy_port_status_page
   import phy_port_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = `CON_DEBOUNCE_MS * `CLK_FREQ_KHZ
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire port_in_s port_in [`PORT_COUNT],
   output logic [`PORT_COUNT-1:0] port_disable,
   output logic [`PORT_COUNT-1:0] port_active,
   output logic [`PORT_COUNT-1:0] scrambler_bypass,
   output logic [`PORT_COUNT-1:0] port_fault_hold,
   output logic [`PORT_COUNT-1:0] standby_errors_clear,
   output speed_t max_speed [`PORT_COUNT],
   output logic port_event_flag,
   output logic link_event_notify
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic speed_t clamp_speed(input speed_t req);
      clamp_speed = (req > `PORT_SPEED_CAP) ? `PORT_SPEED_CAP : req;
   endfunction

   function automatic logic [7:0] sat_inc(input logic [7:0] val, input logic inc);
      sat_inc = (inc && val != `ERR_CNT_MAX) ? val + 8'h01 : val;
   endfunction

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   bus_state_e state;
   bus_state_e next_state;
   logic [3:0] ap_idx;
   logic [2:0] page_sel;
   logic [3:0] port_sel;

   wire accept = hsel && hready && htrans[1];
   wire [3:0] addr_idx = haddr[5:2];
   wire wr_en = (state == BUS_WRITE);
   wire rd_cap = (state == BUS_READ_WAIT);
   wire [7:0] wbyte = hwdata[7:0];
   // Page zero, valid port reach page
   wire port_ok = (port_sel < 4'(`PORT_COUNT));
   // Only page zero is mapped here
   wire page_live = (page_sel == `STATUS_PAGE) && port_ok;
   wire [1:0] sp = port_ok ? port_sel[1:0] : 2'h0;
   wire page_idx = ap_idx[3];

   always_comb begin
      next_state = BUS_IDLE;
      case (state)
         BUS_READ_WAIT: next_state = BUS_READ_DONE;
         BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
            if (accept) begin
               next_state = hwrite ? BUS_WRITE : BUS_READ_WAIT;
            end
         end
         default: next_state = BUS_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= BUS_IDLE;
         ap_idx <= 4'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         state <= next_state;
         hreadyout <= (next_state != BUS_READ_WAIT);
         if (accept && state != BUS_READ_WAIT) begin
            ap_idx <= addr_idx;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         page_sel <= 3'h0;
         port_sel <= 4'h0;
      end else if (wr_en && ap_idx == `REG_SELECT_IDX) begin
         page_sel <= wbyte[`SEL_PAGE_MSB:`SEL_PAGE_LSB];
         port_sel <= wbyte[`SEL_PORT_MSB:`SEL_PORT_LSB];
      end
   end

   // ----------------------------------------
   // Per-port state
   // ----------------------------------------
   logic [`PORT_COUNT-1:0] con;
   logic [`PORT_COUNT-1:0] rx_ok;
   logic [`PORT_COUNT-1:0] irq_en;
   logic [`PORT_COUNT-1:0] fault;
   logic [`PORT_COUNT-1:0] sfault;
   logic [`PORT_COUNT-1:0] unrel;
   logic [`PORT_COUNT-1:0] hard_dis;
   logic [`PORT_COUNT-1:0] stable;
   speed_t agreed [`PORT_COUNT];
   logic [7:0] err_cnt [`PORT_COUNT];
   logic [`DEBOUNCE_W-1:0] deb_cnt [`PORT_COUNT];
   logic [`PORT_COUNT-1:0] evt_hit;

   for (genvar i = 0; i < `PORT_COUNT; i++) begin : g_port
      wire sel_me = page_live && (port_sel[1:0] == 2'(i));
      wire wr_ll = wr_en && sel_me && ap_idx == `REG_LINE_LINK_IDX;
      wire wr_sf = wr_en && sel_me && ap_idx == `REG_SPEED_FAULT_IDX;
      wire wr_sc = wr_en && sel_me && ap_idx == `REG_SPEED_CAP_IDX;
      wire wr_lq = wr_en && sel_me && ap_idx == `REG_LINK_QUAL_IDX;
      wire wr_ls = wr_en && sel_me && ap_idx == `REG_LOOP_STBY_IDX;
      wire rd_clr = (rd_cap && sel_me && ap_idx == `REG_CW_ERR_IDX)
                    || port_in[i].remote_err_read;
      wire forced_off = port_disable[i] && hard_dis[i];
      wire deb_done = (deb_cnt[i] == `DEBOUNCE_W'(DEBOUNCE_CYCLES - 1));
      // Beta link also needs tones and negotiation
      wire con_ok = port_in[i].raw_connect && stable[i] && !forced_off
                    && (!port_in[i].beta_mode
                        || (port_in[i].tones_seen && port_in[i].neg_done));
      // Bias in legacy, valid signal in beta
      wire rx_src = port_in[i].beta_mode ? port_in[i].signal_valid : port_in[i].bias_ok;
      // Resume without bias, suspend with bias
      wire fault_set = (port_in[i].resume_evt && !port_in[i].bias_ok)
                       || (port_in[i].suspend_evt && port_in[i].bias_ok);
      wire sfault_clr = (wr_sf && wbyte[`SF_SFAULT_BIT])
                        || port_in[i].standby_remote_clr || port_in[i].standby_exit;
      wire con_rise = con_ok && !con[i];

      assign evt_hit[i] = irq_en[i] && port_in[i].port_event;

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            deb_cnt[i] <= '0;
            stable[i] <= 1'b0;
         end else if (!port_in[i].raw_connect) begin
            deb_cnt[i] <= '0;
            stable[i] <= 1'b0;
         end else if (!stable[i]) begin
            deb_cnt[i] <= deb_cnt[i] + `DEBOUNCE_W'(1);
            stable[i] <= deb_done;
         end
      end

      // Connection and receive flags; bus reset ignored
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            con[i] <= 1'b0;
            rx_ok[i] <= 1'b0;
         end else begin
            con[i] <= con_ok;
            rx_ok[i] <= rx_src && !forced_off;
         end
      end

      // Disable, enable, bypass, hard disable controls
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            port_disable[i] <= 1'b0;
            irq_en[i] <= 1'b0;
            scrambler_bypass[i] <= 1'b0;
            hard_dis[i] <= 1'b0;
         end else begin
            if (wr_ll) port_disable[i] <= wbyte[`LL_DIS_BIT];
            if (wr_sf) irq_en[i] <= wbyte[`SF_PIE_BIT];
            if (wr_sf) scrambler_bypass[i] <= wbyte[`SF_SCR_BIT];
            if (wr_ls) hard_dis[i] <= wbyte[`LS_HARD_BIT];
         end
      end

      // Sticky flags, set beats write-one clear
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            fault[i] <= 1'b0;
            sfault[i] <= 1'b0;
            unrel[i] <= 1'b0;
            standby_errors_clear[i] <= 1'b0;
         end else begin
            fault[i] <= fault_set || (fault[i] && !(wr_sf && wbyte[`SF_FAULT_BIT]));
            sfault[i] <= port_in[i].standby_err || (sfault[i] && !sfault_clr);
            standby_errors_clear[i] <= sfault_clr && !port_in[i].standby_err;
            unrel[i] <= port_in[i].unreliable_evt
                        || (unrel[i] && !(wr_lq && wbyte[`LQ_UNREL_BIT]));
         end
      end

      // Speed ceiling resets to capability, clamps writes
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            max_speed[i] <= `PORT_SPEED_CAP;
            agreed[i] <= 3'h0;
         end else begin
            if (wr_sc) max_speed[i] <= clamp_speed(wbyte[`SC_MAXSPD_MSB:`SC_MAXSPD_LSB]);
            // Agreed speed at beta connect or self-id
            if (con_rise && port_in[i].beta_mode) begin
               agreed[i] <= clamp_speed(port_in[i].neg_speed);
            end else if (port_in[i].sid_load && !port_in[i].beta_mode) begin
               agreed[i] <= clamp_speed(port_in[i].sid_speed);
            end
         end
      end

      // Saturating counter, read clears before count
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            err_cnt[i] <= 8'h00;
         end else begin
            err_cnt[i] <= sat_inc(rd_clr ? 8'h00 : err_cnt[i], port_in[i].cw_error);
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            port_fault_hold[i] <= 1'b0;
            port_active[i] <= 1'b0;
         end else begin
            port_fault_hold[i] <= fault_set || fault[i];
            port_active[i] <= con[i] && rx_ok[i] && !port_disable[i] && !fault[i];
         end
      end

      // ----------------------------------------
      // Checks
      // ----------------------------------------
      chk_con_debounce: assert property (
         @(posedge hclk) disable iff (!hresetn)
         $rose(con[i]) |-> $past(stable[i]) && $past(port_in[i].raw_connect))
         else $error("connection set before debounce elapsed");
      chk_con_beta_tones: assert property (
         @(posedge hclk) disable iff (!hresetn)
         $rose(con[i]) && $past(port_in[i].beta_mode)
         |-> $past(port_in[i].tones_seen) && $past(port_in[i].neg_done))
         else $error("beta connection without tones and negotiation");
      chk_fault_set: assert property (
         @(posedge hclk) disable iff (!hresetn)
         fault_set |=> fault[i] && port_fault_hold[i])
         else $error("fault not raised on bias mismatch");
      chk_fault_w1c: assert property (
         @(posedge hclk) disable iff (!hresetn)
         wr_sf && wbyte[`SF_FAULT_BIT] && !fault_set |=> !fault[i])
         else $error("fault not cleared by write of one");
      chk_err_saturate: assert property (
         @(posedge hclk) disable iff (!hresetn)
         err_cnt[i] == `ERR_CNT_MAX && !rd_clr |=> err_cnt[i] == `ERR_CNT_MAX)
         else $error("error counter wrapped");
      chk_err_read_clear: assert property (
         @(posedge hclk) disable iff (!hresetn)
         rd_clr |=> err_cnt[i] == {7'h00, $past(port_in[i].cw_error)})
         else $error("error counter not cleared by read");
      chk_speed_ceiling: assert property (
         @(posedge hclk) disable iff (!hresetn)
         max_speed[i] <= `PORT_SPEED_CAP)
         else $error("speed ceiling above capability");
      chk_disable_idle: assert property (
         @(posedge hclk) disable iff (!hresetn)
         port_disable[i] ##1 port_disable[i] |-> !port_active[i])
         else $error("disabled port became active");
      cov_connect: cover property (@(posedge hclk) disable iff (!hresetn) $rose(con[i]));
      cov_fault: cover property (@(posedge hclk) disable iff (!hresetn) $fell(fault[i]));
      cov_err_sat: cover property (@(posedge hclk) disable iff (!hresetn)
         err_cnt[i] == `ERR_CNT_MAX);
   end : g_port

   // ----------------------------------------
   // Global port event flag
   // ----------------------------------------
   wire evt_any = |evt_hit;
   wire evt_clr = wr_en && ap_idx == `REG_EVENT_IDX && wbyte[`EV_FLAG_BIT];

   // Enabled port event sets flag, notifies link
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_event_flag <= 1'b0;
         link_event_notify <= 1'b0;
      end else begin
         port_event_flag <= evt_any || (port_event_flag && !evt_clr);
         link_event_notify <= evt_any;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   port_in_s si;
   assign si = port_in[sp];
   // Idle, disabled or suspended ports read child
   wire child_rd = !con[sp] || port_disable[sp] || si.suspended || si.child;
   wire [7:0] rd_ll = {si.line_a, si.line_b, child_rd, con[sp], rx_ok[sp], port_disable[sp]};
   wire [7:0] rd_sf = {agreed[sp], irq_en[sp], fault[sp], sfault[sp],
                       scrambler_bypass[sp], `BETA_ONLY};
   wire [7:0] rd_sc = {si.dc_attach, max_speed[sp], `LOCAL_PLUG, `PORT_SPEED_CAP};
   wire [7:0] rd_lq = {unrel[sp], 3'h0, si.beta_mode, 3'h0};
   wire [7:0] rd_ls = {5'h00, si.loop_disable, si.in_standby, hard_dis[sp]};

   logic [7:0] page_byte;
   always_comb begin
      case (ap_idx)
         `REG_LINE_LINK_IDX: page_byte = rd_ll;
         `REG_SPEED_FAULT_IDX: page_byte = rd_sf;
         `REG_SPEED_CAP_IDX: page_byte = rd_sc;
         `REG_LINK_QUAL_IDX: page_byte = rd_lq;
         `REG_CW_ERR_IDX: page_byte = err_cnt[sp];
         default: page_byte = 8'h00;
      endcase
   end

   // Missing port or other page reads zero
   wire [7:0] rd_byte = page_idx ? (page_live ? page_byte : 8'h00)
                      : (ap_idx == `REG_SELECT_IDX) ? {page_sel, 1'b0, port_sel}
                      : (ap_idx == `REG_EVENT_IDX) ? {7'h00, port_event_flag}
                      : 8'h00;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_cap) begin
         hrdata <= {24'h00_0000, rd_byte};
      end
   end

   chk_missing_port_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_cap && page_idx && !port_ok |=> hrdata == 32'h0000_0000)
      else $error("missing port read nonzero");
   chk_reserved_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_cap && ap_idx >= `REG_RSVD_E_IDX |=> hrdata == 32'h0000_0000)
      else $error("reserved address read nonzero");
   chk_event_flag: assert property (
      @(posedge hclk) disable iff (!hresetn)
      evt_any |=> port_event_flag && link_event_notify)
      else $error("port event not flagged");
   chk_read_wait: assert property (
      @(posedge hclk) disable iff (!hresetn)
      accept && !hwrite && state != BUS_READ_WAIT |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   cov_read: cover property (@(posedge hclk) disable iff (!hresetn)
      rd_cap && page_live && ap_idx == `REG_LINE_LINK_IDX);
   cov_event: cover property (@(posedge hclk) disable iff (!hresetn) $fell(port_event_flag));

endmodule // phy_port_status_page

// ===== testbench/port_side_model.sv
`timescale 1ns/1ps
`include "phy_port_map.svh"
module port_side_model
   import phy_port_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire port_in_s cfg [`PORT_COUNT],
   output port_in_s port_in [`PORT_COUNT]
);
   // ----------------------------------------
   // Transceiver and arbitration side
   // ----------------------------------------
   // Registered so every level and pulse lands one cycle after the bench sets it,
   // the way sampled transceiver status would reach the register page
   // line codes registered like the rest
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `PORT_COUNT; i++)
            port_in[i] <= '0;
      end else begin
         for (int i = 0; i < `PORT_COUNT; i++)
            port_in[i] <= cfg[i];
      end
   end
endmodule // port_side_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`include "phy_port_map.svh"
module tb_top
   import phy_port_pkg::*;
   ;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, port_event_flag, link_event_notify;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [`PORT_COUNT-1:0] port_disable, port_active, scrambler_bypass, port_fault_hold;
   logic [`PORT_COUNT-1:0] standby_errors_clear;
   speed_t max_speed [`PORT_COUNT];
   port_in_s cfg [`PORT_COUNT];
   port_in_s port_in [`PORT_COUNT];
   int error_cnt, checks_done, cycles;

   // ----------------------------------------
   // Clock, design and far side
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // Short debounce keeps the connect scenario fast
   phy_port_status_page #(.DEBOUNCE_CYCLES(16)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .port_in(port_in), .port_disable(port_disable),
      .port_active(port_active), .scrambler_bypass(scrambler_bypass),
      .port_fault_hold(port_fault_hold), .standby_errors_clear(standby_errors_clear),
      .max_speed(max_speed), .port_event_flag(port_event_flag),
      .link_event_notify(link_event_notify));

   port_side_model far_side (.hclk(hclk), .hresetn(hresetn), .cfg(cfg), .port_in(port_in));

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Called just after a rising edge; each phase stands until hready is
   // sampled high at a rising edge, read data taken at that same edge
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
         output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {26'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] unused;
      bus(1'b1, idx, d, unused);
   endtask

   task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
      logic [31:0] v;
      bus(1'b0, idx, 8'h00, v);
      check(v, {24'h0, exp});
   endtask

   task automatic sel(input logic [3:0] port);
      wr(`REG_SELECT_IDX, {4'h0, port});
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      sel(4'h0);
      rd_chk(`REG_SPEED_FAULT_IDX, 8'h00);
      rd_chk(`REG_SPEED_CAP_IDX, 8'h3b);
      check({29'h0, max_speed[0]}, 32'h3);
      check({31'h0, hresp}, 32'h0);
   endtask

   task automatic t_connect;
      cfg[0].line_a <= 2'b01;
      cfg[0].line_b <= 2'b10;
      cfg[0].raw_connect <= 1'b1;
      repeat (4) @(posedge hclk);
      // Not yet stable, and a disconnected port reads as child
      rd_chk(`REG_LINE_LINK_IDX, 8'h68);
      cfg[0].bias_ok <= 1'b1;
      repeat (40) @(posedge hclk);
      rd_chk(`REG_LINE_LINK_IDX, 8'h66);
      check({31'h0, port_active[0]}, 32'h1);
      wr(`REG_LINE_LINK_IDX, 8'h01);
      rd_chk(`REG_LINE_LINK_IDX, 8'h6f);
      check({31'h0, port_active[0]}, 32'h0);
      check({31'h0, port_disable[0]}, 32'h1);
      cfg[0].line_a <= 2'b11;
      cfg[0].line_b <= 2'b00;
      repeat (2) @(posedge hclk);
      rd_chk(`REG_LINE_LINK_IDX, 8'hcf);
   endtask

   task automatic t_fault;
      sel(4'h1);
      cfg[1].resume_evt <= 1'b1;
      @(posedge hclk);
      cfg[1].resume_evt <= 1'b0;
      rd_chk(`REG_SPEED_FAULT_IDX, 8'h08);
      check({31'h0, port_fault_hold[1]}, 32'h1);
      wr(`REG_SPEED_FAULT_IDX, 8'h08);
      rd_chk(`REG_SPEED_FAULT_IDX, 8'h00);
      cfg[1].bias_ok <= 1'b1;
      cfg[1].suspend_evt <= 1'b1;
      @(posedge hclk);
      cfg[1].suspend_evt <= 1'b0;
      rd_chk(`REG_SPEED_FAULT_IDX, 8'h08);
      wr(`REG_SPEED_FAULT_IDX, 8'h12);
      rd_chk(`REG_SPEED_FAULT_IDX, 8'h1a);
      check({31'h0, scrambler_bypass[1]}, 32'h1);
      cfg[1].port_event <= 1'b1;
      @(posedge hclk);
      cfg[1].port_event <= 1'b0;
      repeat (2) @(posedge hclk);
      check({31'h0, port_event_flag}, 32'h1);
      check({31'h0, link_event_notify}, 32'h1);
      rd_chk(`REG_EVENT_IDX, 8'h01);
      cfg[1].standby_err <= 1'b1;
      @(posedge hclk);
      cfg[1].standby_err <= 1'b0;
      rd_chk(`REG_SPEED_FAULT_IDX, 8'h1e);
      wr(`REG_SPEED_FAULT_IDX, 8'h16);
      @(posedge hclk);
      check({31'h0, standby_errors_clear[1]}, 32'h1);
      rd_chk(`REG_SPEED_FAULT_IDX, 8'h1a);
   endtask

   task automatic t_counter;
      sel(4'h2);
      repeat (3) begin
         cfg[2].cw_error <= 1'b1;
         @(posedge hclk);
         cfg[2].cw_error <= 1'b0;
         @(posedge hclk);
      end
      rd_chk(`REG_CW_ERR_IDX, 8'h03);
      rd_chk(`REG_CW_ERR_IDX, 8'h00);
      wr(`REG_SPEED_CAP_IDX, 8'h70);
      rd_chk(`REG_SPEED_CAP_IDX, 8'h3b);
      wr(`REG_SPEED_CAP_IDX, 8'h10);
      rd_chk(`REG_SPEED_CAP_IDX, 8'h1b);
      check({29'h0, max_speed[2]}, 32'h1);
      cfg[2].sid_speed <= 3'h2;
      cfg[2].sid_load <= 1'b1;
      @(posedge hclk);
      cfg[2].sid_load <= 1'b0;
      rd_chk(`REG_SPEED_FAULT_IDX, 8'h40);
      cfg[2].unreliable_evt <= 1'b1;
      cfg[2].dc_attach <= 1'b1;
      cfg[2].beta_mode <= 1'b1;
      @(posedge hclk);
      cfg[2].unreliable_evt <= 1'b0;
      rd_chk(`REG_LINK_QUAL_IDX, 8'h88);
      rd_chk(`REG_SPEED_CAP_IDX, 8'h9b);
      wr(`REG_LINK_QUAL_IDX, 8'h80);
      rd_chk(`REG_LINK_QUAL_IDX, 8'h08);
      wr(`REG_RSVD_E_IDX, 8'hff);
      rd_chk(`REG_RSVD_E_IDX, 8'h00);
      rd_chk(`REG_RSVD_F_IDX, 8'h00);
   endtask

   task automatic t_missing;
      cfg[0].line_a <= 2'b01;
      sel(4'h3);
      for (int i = 8; i < 16; i++)
         rd_chk(i[3:0], 8'h00);
   endtask

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         finish_test;
      end
   end

   initial begin
      error_cnt = 0;
      checks_done = 0;
      cycles = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      for (int i = 0; i < `PORT_COUNT; i++)
         cfg[i] = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_connect;
      t_fault;
      t_counter;
      t_missing;
      finish_test;
   end
endmodule // tb_top
